// file: verilog/qdr_pkg.sv
// qdr_pkg: constants, field layout and helpers of the quad converter
// readback and power-down block.
// assumes nothing beyond a SystemVerilog-2012 compiler.
`default_nettype none

package qdr_pkg;

    localparam int unsigned DATA_W        = 12;
    localparam int unsigned REG_W         = 14;
    localparam int unsigned NUM_CH        = 4;

    // fixed upper five address bits, the two low bits come from the pins
    localparam logic [4:0]  ADDR_BASE     = 5'h13;

    // control byte: 0 0 load[1:0] x sel[1:0] powerdown_flag
    localparam int unsigned CTRL_PD_BIT   = 0;
    localparam int unsigned CTRL_SEL_LSB  = 1;
    localparam int unsigned CTRL_LOAD_LSB = 4;
    localparam int unsigned MSB_MODE_LSB  = 6;

    // load modes
    localparam logic [1:0]  LOAD_TEMP     = 2'h0;
    localparam logic [1:0]  LOAD_ONE      = 2'h1;
    localparam logic [1:0]  LOAD_ALL      = 2'h2;
    localparam logic [1:0]  LOAD_BCAST    = 2'h3;

    // stored power-down modes
    localparam logic [1:0]  PDM_HIZ       = 2'h0;
    localparam logic [1:0]  PDM_1K        = 2'h1;
    localparam logic [1:0]  PDM_100K      = 2'h2;
    localparam logic [1:0]  PDM_HIZ_ALT   = 2'h3;

    localparam logic [5:0]  PD_FILL       = 6'h3F;
    localparam logic [3:0]  LOW_PAD       = 4'h0;
    localparam logic [13:0] CONV_RESET    = 14'h0000;

    // received byte index within a frame
    localparam logic [1:0]  IDX_ADDR      = 2'h0;
    localparam logic [1:0]  IDX_CTRL      = 2'h1;
    localparam logic [1:0]  IDX_MSB       = 2'h2;
    localparam logic [1:0]  IDX_LSB       = 2'h3;

    // transmitted byte number
    localparam logic [1:0]  TX_PD         = 2'h0;
    localparam logic [1:0]  TX_HI         = 2'h1;
    localparam logic [1:0]  TX_LO         = 2'h2;

    localparam logic [2:0]  BIT_LAST      = 3'h7;

    typedef enum logic [4:0] {
        LS_IDLE = 5'b00001,
        LS_RX   = 5'b00010,
        LS_RACK = 5'b00100,
        LS_TX   = 5'b01000,
        LS_TACK = 5'b10000
    } qdr_link_state_t;

    function automatic logic [7:0] qdr_tx_byte(
        input logic [1:0]  num,
        input logic [13:0] word
    );
        unique case (num)
            TX_PD:   return {word[13:12], PD_FILL};
            TX_HI:   return word[11:4];
            default: return {word[3:0], LOW_PAD};
        endcase
    endfunction : qdr_tx_byte

    // a set flag only replaces the mode bits, data stays as it was
    function automatic logic [13:0] qdr_merge(
        input logic [13:0] old,
        input logic        pd,
        input logic [7:0]  msb,
        input logic [7:0]  lsb
    );
        if (pd)
            return {msb[MSB_MODE_LSB +: 2], old[11:0]};
        return {2'h0, msb, lsb[7:4]};
    endfunction : qdr_merge

endpackage : qdr_pkg

`default_nettype wire

// file: verilog/qdr_tgl_sync.sv
// qdr_tgl_sync: carries a toggle event into the clock domain of clk_in.
// assumes the toggle changes no faster than once per four clk_in edges.
`default_nettype none

module qdr_tgl_sync
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic tgl_in,
    output logic      pulse_out
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= tgl_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign pulse_out = sync_q ^ last_q;

endmodule : qdr_tgl_sync

`default_nettype wire

// file: verilog/qdr_core.sv
// qdr_core: serial slave link, readback path and channel registers of a
// quad 12-bit converter.
// assumes an open-drain bus resolved outside; scl_in is the bus clock.
`default_nettype none

// Contract
// - the high-speed master code is never acknowledged.
// - matching write address and the following control byte are acknowledged.
// - channel-select bits of latest control byte pick the channel read back.
// - flag clear returns high byte then low byte, two bytes only.
// - flag set returns power-down byte, high byte, low byte.
// - control byte: two zeros, load bits, select bits, flag in bit 0.
// - power-down byte has mode bits on top, six lower bits ones.
// - power-up clears every converter register to zero.
// - with flag set, top two bits of first data byte choose the mode.
// - with flag clear each channel loaded from the data bytes runs normally; update-all copies the others' temporary mode bits.
// - entering power-down keeps the stored twelve data bits.
// - each channel has 14-bit temporary and converter registers.
// - with flag set, mode bits go into bits 13 and 12.
// - power-down conditions follow the same load modes as data.
// - the serial clock line is never driven low.
module qdr_core
    import qdr_pkg::*;
#(
    parameter int unsigned CHANNELS = NUM_CH
)
(
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    input  wire logic                      addr_pin_hi_in,
    input  wire logic                      addr_pin_lo_in,
    output logic                           sda_out,
    output logic                           sda_oe_n_out,
    output logic                           scl_out,
    output logic                           scl_oe_n_out,
    output logic [CHANNELS*REG_W-1:0]      convert_value_out
);

    if (CHANNELS != NUM_CH)
    begin : g_chk
        $error("qdr_core: two select bits serve exactly four channels");
    end

    // ---------------- link reset, asserted at once, released on scl
    logic       por_q;
    logic [1:0] lrst_q;
    logic       link_rst;

    always_ff @(posedge core_clk_in)
        por_q <= rst_in;

    always_ff @(posedge scl_in or posedge por_q)
    begin
        if (por_q)
            lrst_q <= 2'h3;
        else
            lrst_q <= {lrst_q[0], 1'b0};
    end

    assign link_rst = lrst_q[1];

    // ---------------- start detection: sda falling while scl high
    // set only while scl is high, so it is stable at the next scl rise
    logic start_q;
    logic clr_q;
    logic start_clr;

    assign start_clr = link_rst | clr_q;

    always_ff @(negedge sda_in or posedge start_clr)
    begin
        if (start_clr)
            start_q <= 1'b0;
        else if (scl_in)
            start_q <= 1'b1;
    end

    // ---------------- link domain state
    qdr_link_state_t state_q, state_d;
    logic [1:0]  apin_m_q, apin_q;
    logic [6:0]  rx_sh_q, rx_sh_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [1:0]  idx_q, idx_d;
    logic        rw_q, rw_d;
    logic [7:0]  lk_ctrl_q, lk_ctrl_d;
    logic [7:0]  lk_msb_q, lk_msb_d;
    logic [7:0]  lk_lsb_q, lk_lsb_d;
    logic        ctrl_tgl_q, ctrl_tgl_d;
    logic        wr_tgl_q, wr_tgl_d;
    logic [7:0]  tx_sh_q, tx_sh_d;
    logic [1:0]  tx_num_q, tx_num_d;
    logic [13:0] rd_snap_q;
    logic [13:0] rd_word_q;
    logic        rd_tgl_q;
    logic        rd_evt;
    logic        drive_q;

    wire  [7:0]  rx_byte  = {rx_sh_q, sda_in};
    wire         rx_done  = (state_q == LS_RX) && (cnt_q == BIT_LAST)
                            && !start_q;
    wire         addr_hit = (rx_byte[7:3] == ADDR_BASE)
                            && (rx_byte[2:1] == apin_q);
    wire         ctl_pd   = lk_ctrl_q[CTRL_PD_BIT];
    // flag set opens with power-down byte
    wire  [1:0]  first_tx = ctl_pd ? TX_PD : TX_HI;
    wire  [1:0]  next_tx  = tx_num_q + 2'h1;
    // ack in LS_RACK, data bits in LS_TX
    wire         drive_d  = (state_q == LS_RACK)
                            || ((state_q == LS_TX) && !tx_sh_q[7]);

    always_comb
    begin
        state_d    = state_q;
        cnt_d      = cnt_q + 3'h1;
        idx_d      = idx_q;
        rw_d       = rw_q;
        lk_ctrl_d  = lk_ctrl_q;
        lk_msb_d   = lk_msb_q;
        lk_lsb_d   = lk_lsb_q;
        ctrl_tgl_d = ctrl_tgl_q;
        wr_tgl_d   = wr_tgl_q;
        tx_sh_d    = {tx_sh_q[6:0], 1'b1};
        tx_num_d   = tx_num_q;
        rx_sh_d    = {rx_sh_q[5:0], sda_in};
        if (start_q)
        begin
            state_d = LS_RX;
            idx_d   = IDX_ADDR;
            cnt_d   = 3'h1;
            rx_sh_d = {6'h00, sda_in};
        end
        else
        begin
            unique case (state_q)
                LS_IDLE: cnt_d = cnt_q;
                LS_RX:
                begin
                    if (cnt_q == BIT_LAST)
                    begin
                        state_d = LS_RACK;
                        unique case (idx_q)
                            IDX_ADDR:
                            begin
                                rw_d = rx_byte[0];
                                // foreign codes fall idle, no ack
                                if (!addr_hit)
                                    state_d = LS_IDLE;
                            end
                            IDX_CTRL:
                            begin
                                lk_ctrl_d  = rx_byte;
                                ctrl_tgl_d = !ctrl_tgl_q;
                            end
                            IDX_MSB: lk_msb_d = rx_byte;
                            IDX_LSB:
                            begin
                                lk_lsb_d = rx_byte;
                                wr_tgl_d = !wr_tgl_q;
                            end
                        endcase
                    end
                end
                LS_RACK:
                begin
                    cnt_d = 3'h0;
                    if ((idx_q == IDX_ADDR) && rw_q)
                    begin
                        state_d  = LS_TX;
                        tx_num_d = first_tx;
                        tx_sh_d  = qdr_tx_byte(first_tx, rd_snap_q);
                    end
                    else
                    begin
                        state_d = LS_RX;
                        idx_d   = (idx_q == IDX_LSB) ? IDX_MSB
                                                     : idx_q + 2'h1;
                    end
                end
                LS_TX:
                begin
                    if (cnt_q == BIT_LAST)
                        state_d = LS_TACK;
                end
                LS_TACK:
                begin
                    cnt_d = 3'h0;
                    // low byte is always last, nack ends early
                    if (!sda_in && (tx_num_q != TX_LO))
                    begin
                        state_d  = LS_TX;
                        tx_num_d = next_tx;
                        tx_sh_d  = qdr_tx_byte(next_tx, rd_snap_q);
                    end
                    else
                        state_d = LS_IDLE;
                end
                default: state_d = LS_IDLE;
            endcase
        end
    end

    always_ff @(posedge scl_in)
    begin
        if (link_rst)
        begin
            state_q    <= LS_IDLE;
            cnt_q      <= 3'h0;
            idx_q      <= IDX_ADDR;
            rw_q       <= 1'b0;
            rx_sh_q    <= 7'h00;
            lk_ctrl_q  <= 8'h00;
            lk_msb_q   <= 8'h00;
            lk_lsb_q   <= 8'h00;
            ctrl_tgl_q <= 1'b0;
            wr_tgl_q   <= 1'b0;
            tx_sh_q    <= 8'hFF;
            tx_num_q   <= TX_HI;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            idx_q      <= idx_d;
            rw_q       <= rw_d;
            rx_sh_q    <= rx_sh_d;
            lk_ctrl_q  <= lk_ctrl_d;
            lk_msb_q   <= lk_msb_d;
            lk_lsb_q   <= lk_lsb_d;
            ctrl_tgl_q <= ctrl_tgl_d;
            wr_tgl_q   <= wr_tgl_d;
            tx_sh_q    <= tx_sh_d;
            tx_num_q   <= tx_num_d;
        end
    end

    always_ff @(posedge scl_in)
    begin
        if (link_rst)
        begin
            clr_q     <= 1'b0;
            apin_m_q  <= 2'h0;
            apin_q    <= 2'h0;
            rd_snap_q <= CONV_RESET;
        end
        else
        begin
            clr_q     <= start_q;
            apin_m_q  <= {addr_pin_hi_in, addr_pin_lo_in};
            apin_q    <= apin_m_q;
            rd_snap_q <= rd_evt ? rd_word_q : rd_snap_q;
        end
    end

    // data changes on the falling edge, away from the master's sampling
    always_ff @(negedge scl_in)
    begin
        if (link_rst)
            drive_q <= 1'b0;
        else
            drive_q <= drive_d;
    end

    assign sda_out      = 1'b0;
    assign sda_oe_n_out = !(drive_q && !link_rst);
    assign scl_out      = 1'b1;
    assign scl_oe_n_out = 1'b1;

    // ---------------- crossings
    logic ctrl_evt;
    logic wr_evt;

    qdr_tgl_sync u_ctrl_sync
    (
        .clk_in    (core_clk_in),
        .rst_in    (rst_in),
        .tgl_in    (ctrl_tgl_q),
        .pulse_out (ctrl_evt)
    );

    qdr_tgl_sync u_wr_sync
    (
        .clk_in    (core_clk_in),
        .rst_in    (rst_in),
        .tgl_in    (wr_tgl_q),
        .pulse_out (wr_evt)
    );

    qdr_tgl_sync u_rd_sync
    (
        .clk_in    (scl_in),
        .rst_in    (link_rst),
        .tgl_in    (rd_tgl_q),
        .pulse_out (rd_evt)
    );

    // ---------------- channel registers, core domain
    logic [CHANNELS-1:0][REG_W-1:0] th_q, th_d;
    logic [CHANNELS-1:0][REG_W-1:0] cv_q, cv_d;
    logic [1:0] sel_q;
    logic       upd_q;

    // link holding registers stay still until the next byte pair
    wire  [1:0] w_ch   = lk_ctrl_q[CTRL_SEL_LSB +: 2];
    wire  [1:0] w_load = lk_ctrl_q[CTRL_LOAD_LSB +: 2];

    always_comb
    begin
        th_d = th_q;
        cv_d = cv_q;
        if (wr_evt)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                // mode bits only with flag set
                if ((w_load == LOAD_BCAST) || (2'(i) == w_ch))
                    th_d[i] = qdr_merge(th_q[i], ctl_pd, lk_msb_q, lk_lsb_q);
                // converter load follows the same modes
                if ((w_load == LOAD_BCAST)
                    || ((w_load == LOAD_ONE) && (2'(i) == w_ch)))
                    cv_d[i] = qdr_merge(cv_q[i], ctl_pd, lk_msb_q, lk_lsb_q);
                else if (w_load == LOAD_ALL)
                    cv_d[i] = th_d[i];
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            th_q <= '0;
            cv_q <= '0;
        end
        else
        begin
            th_q <= th_d;
            cv_q <= cv_d;
        end
    end

    // readback word of the selected channel
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            sel_q     <= 2'h0;
            upd_q     <= 1'b0;
            rd_word_q <= CONV_RESET;
            rd_tgl_q  <= 1'b0;
        end
        else
        begin
            sel_q     <= ctrl_evt ? w_ch : sel_q;
            upd_q     <= ctrl_evt || wr_evt;
            rd_word_q <= upd_q ? cv_q[sel_q] : rd_word_q;
            rd_tgl_q  <= rd_tgl_q ^ upd_q;
        end
    end

    assign convert_value_out = cv_q;

    // ---------------- checks
    logic [1:0]  chk_ch_q;
    logic [11:0] chk_old_q;
    logic [1:0]  chk_mode_q;

    always_ff @(posedge core_clk_in)
    begin
        chk_ch_q   <= w_ch;
        chk_old_q  <= cv_q[w_ch][11:0];
        chk_mode_q <= lk_msb_q[MSB_MODE_LSB +: 2];
    end

    hs_code_nack_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (rx_done && (idx_q == IDX_ADDR) && !addr_hit) |=> sda_oe_n_out)
        else $error("foreign address or master code was acknowledged");
    addr_ack_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (rx_done && (idx_q == IDX_ADDR) && addr_hit) |=> !sda_oe_n_out)
        else $error("own address not acknowledged");
    ctrl_ack_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (rx_done && (idx_q == IDX_CTRL)) |=> !sda_oe_n_out ##1 1)
        else $error("control byte not acknowledged");
    two_byte_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (state_q == LS_TACK && tx_num_q == TX_LO && !start_q)
        |=> (state_q == LS_IDLE) ##1 sda_oe_n_out)
        else $error("transmission ran past the low byte");
    three_byte_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (state_q == LS_RACK && idx_q == IDX_ADDR && rw_q && !start_q)
        |=> (tx_num_q == (ctl_pd ? TX_PD : TX_HI)))
        else $error("wrong first readback byte");
    pd_byte_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (state_q == LS_TX && cnt_q == 3'h0 && tx_num_q == TX_PD)
        |-> tx_sh_q == {rd_snap_q[13:12], PD_FILL})
        else $error("power-down byte malformed");
    hi_byte_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (state_q == LS_TX && cnt_q == 3'h0 && tx_num_q == TX_HI)
        |-> tx_sh_q == rd_snap_q[11:4])
        else $error("high byte malformed");
    idle_quiet_a: assert property (@(posedge scl_in) disable iff (link_rst)
        (state_q == LS_IDLE && !start_q) |=> $stable(state_q) ##1 sda_oe_n_out)
        else $error("idle link left idle without a start");
    por_clear_a: assert property (@(posedge core_clk_in)
        rst_in |=> (convert_value_out == '0))
        else $error("converter registers not cleared");
    sel_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ctrl_evt && !wr_evt) ##1 !wr_evt |=> rd_word_q == cv_q[sel_q])
        else $error("readback word not from selected channel");
    pd_keep_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr_evt && ctl_pd && w_load == LOAD_ONE)
        |=> cv_q[chk_ch_q][11:0] == chk_old_q)
        else $error("power-down changed stored data");
    mode_store_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr_evt && ctl_pd) |=> th_q[chk_ch_q][13:12] == chk_mode_q)
        else $error("mode bits not stored");
    normal_mode_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr_evt && !ctl_pd && w_load == LOAD_ONE)
        |=> cv_q[chk_ch_q][13:12] == PDM_HIZ)
        else $error("normal write left a power-down mode");
    load_all_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr_evt && w_load == LOAD_ALL) |=> cv_q == th_q)
        else $error("update-all did not copy temporary registers");

    read3_c: cover property (@(posedge scl_in) disable iff (link_rst)
        state_q == LS_TACK && tx_num_q == TX_LO && ctl_pd);
    read2_c: cover property (@(posedge scl_in) disable iff (link_rst)
        state_q == LS_TACK && tx_num_q == TX_LO && !ctl_pd);
    hs_nack_c: cover property (@(posedge scl_in) disable iff (link_rst)
        rx_done && idx_q == IDX_ADDR && rx_byte[7:3] == 5'h01);
    pd_write_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        wr_evt && ctl_pd);

endmodule : qdr_core

`default_nettype wire

// file: test/qdr_i2c_master.sv
// qdr_i2c_master: bus master model that drives the serial link.
// assumes sda is resolved by the bench with a pull-up.
`default_nettype none
module qdr_i2c_master
(
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 40;
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // idle pulses let the link reset release
    task automatic idle();
        repeat (3)
        begin
            #(2*Q) scl_out = 1'b0;
            #(2*Q) scl_out = 1'b1;
        end
    endtask : idle
    task automatic start();
        #Q sda_out = 1'b1;
        #Q scl_out = 1'b1;
        #Q sda_out = 1'b0;
        #Q scl_out = 1'b0;
    endtask : start
    task automatic stop();
        #Q sda_out = 1'b0;
        #Q scl_out = 1'b1;
        #Q sda_out = 1'b1;
    endtask : stop
    task automatic bit_io(input logic b, output logic s);
        #Q sda_out = b;
        #Q scl_out = 1'b1;
        #Q s = sda_in;
        #Q scl_out = 1'b0;
    endtask : bit_io
    task automatic wr(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], ack);
        bit_io(1'b1, ack);
    endtask : wr
    // ack every byte but the last
    task automatic rd(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask : rd
    task automatic hs(output logic ack);
        start();
        wr(8'h08, ack);
    endtask : hs
endmodule : qdr_i2c_master
`default_nettype wire

// file: test/test_quad_dac_readback_powerdown.sv
// test_quad_dac_readback_powerdown: writes and readback over the link,
// checked against a reference model of the channel registers.
// assumes the master model and an open-drain bus with pull-ups.
`default_nettype none
module test_quad_dac_readback_powerdown
    import qdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 core_clk_in = 1'b0;
    logic                 rst_in      = 1'b1;
    logic                 mst_scl;
    logic                 mst_sda;
    wire logic            dsda;
    wire logic            dsda_oe_n;
    wire logic            dscl;
    wire logic            dscl_oe_n;
    wire logic [4*REG_W-1:0] conv;
    int                   err_count = 0;
    int                   checked   = 0;
    logic [13:0]          tmp [4];
    logic [13:0]          cv  [4];
    logic [7:0]           b;
    logic                 a;
    logic [1:0]           pins      = 2'h2;
    wire logic            scl = mst_scl & (dscl_oe_n | dscl);
    wire logic            sda = mst_sda & (dsda_oe_n | dsda);

    always #50 core_clk_in = ~core_clk_in;

    qdr_core u_dut
    (
        .core_clk_in       (core_clk_in),
        .rst_in            (rst_in),
        .scl_in            (scl),
        .sda_in            (sda),
        .addr_pin_hi_in    (pins[1]),
        .addr_pin_lo_in    (pins[0]),
        .sda_out           (dsda),
        .sda_oe_n_out      (dsda_oe_n),
        .scl_out           (dscl),
        .scl_oe_n_out      (dscl_oe_n),
        .convert_value_out (conv)
    );
    qdr_i2c_master u_mst
    (
        .sda_in  (sda),
        .scl_out (mst_scl),
        .sda_out (mst_sda)
    );

    task automatic results();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check

    function automatic logic [13:0] mix(input logic [13:0] o,
        input logic pd, input logic [7:0] m, input logic [7:0] l);
        return pd ? {m[7:6], o[11:0]} : {2'h0, m, l[7:4]};
    endfunction : mix

    task automatic cmp_all();
        repeat (10) @(posedge core_clk_in);
        #1;
        for (int i = 0; i < 4; i++)
            check(conv[i*REG_W +: REG_W], cv[i]);
    endtask : cmp_all

    task automatic head(input logic [7:0] c);
        u_mst.start();
        u_mst.wr({ADDR_BASE, pins, 1'b0}, a);
        check(a, 1'b0);
        u_mst.wr(c, a);
        check(a, 1'b0);
    endtask : head

    task automatic wr_word(input logic [1:0] ld, input logic [1:0] ch,
        input logic pd, input logic [7:0] m, input logic [7:0] l);
        head({2'h0, ld, 1'b0, ch, pd});
        u_mst.wr(m, a);
        u_mst.wr(l, a);
        u_mst.stop();
        for (int i = 0; i < 4; i++)
            if (ld == LOAD_BCAST || i == ch)
                tmp[i] = mix(tmp[i], pd, m, l);
        for (int i = 0; i < 4; i++)
            if (ld == LOAD_ALL)
                cv[i] = tmp[i];
            else if (ld != LOAD_TEMP && (ld == LOAD_BCAST || i == ch))
                cv[i] = mix(cv[i], pd, m, l);
        cmp_all();
    endtask : wr_word

    task automatic rd_back(input logic [1:0] ch, input logic pd,
        input logic more);
        head({2'h0, LOAD_TEMP, 1'b0, ch, pd});
        #3us;
        u_mst.start();
        u_mst.wr({ADDR_BASE, pins, 1'b1}, a);
        check(a, 1'b0);
        if (pd)
        begin
            u_mst.rd(1'b0, b);
            check(b, {cv[ch][13:12], 6'h3F});
        end
        u_mst.rd(1'b0, b);
        check(b, cv[ch][11:4]);
        u_mst.rd(~more, b);
        check(b[7:4], cv[ch][3:0]);
        if (more)
        begin
            // an extra byte finds the line released
            u_mst.rd(1'b1, b);
            check(b, 8'hFF);
        end
        u_mst.stop();
    endtask : rd_back

    initial
    begin
        #1ms;
        err_count++;
        results();
    end

    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            cv[i]  = CONV_RESET;
            tmp[i] = CONV_RESET;
        end
        repeat (3) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        cmp_all();
        check({dscl_oe_n, dscl}, 2'h3);
        check(dsda, 1'b0);
        u_mst.idle();
        u_mst.hs(a);
        check(a, 1'b1);
        wr_word(LOAD_BCAST, 2'h0, 1'b0, 8'h5A, 8'h60);
        wr_word(LOAD_ONE, 2'h2, 1'b0, 8'hA5, 8'hC3);
        wr_word(LOAD_ONE, 2'h2, 1'b1, 8'h80, 8'h00);
        rd_back(2'h2, 1'b1, 1'b0);
        wr_word(LOAD_TEMP, 2'h1, 1'b0, 8'h3C, 8'h90);
        wr_word(LOAD_ALL, 2'h0, 1'b0, 8'h12, 8'h30);
        wr_word(LOAD_BCAST, 2'h1, 1'b1, 8'h40, 8'h00);
        wr_word(LOAD_ONE, 2'h3, 1'b0, 8'hFF, 8'hF0);
        rd_back(2'h3, 1'b0, 1'b0);
        rd_back(2'h2, 1'b0, 1'b1);
        rd_back(2'h0, 1'b1, 1'b0);
        u_mst.start();
        u_mst.wr({ADDR_BASE, 2'h1, 1'b0}, a);
        check(a, 1'b1);
        u_mst.wr(8'h11, a);
        check(a, 1'b1);
        u_mst.stop();
        cmp_all();
        check(dscl_oe_n, 1'b1);
        pins = 2'h1;
        u_mst.start();
        u_mst.wr({ADDR_BASE, 2'h2, 1'b0}, a);
        check(a, 1'b1);
        u_mst.stop();
        wr_word(LOAD_ONE, 2'h1, 1'b0, 8'h77, 8'h70);
        rd_back(2'h1, 1'b1, 1'b0);
        results();
    end
endmodule : test_quad_dac_readback_powerdown
`default_nettype wire
